// ### rtl/gds_pkg.sv
// Shared constants and types for the gate driver serial front end
package gds_pkg;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_ADDR_CFG,
        ST_REG_CFG,
        ST_ACTIVE
    } gds_state_t;

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 12;
    localparam logic [3:0] ADDR_ZERO = 4'h0;
    localparam logic [3:0] ADDR_BCAST = 4'hf;
    localparam logic [3:0] DEVICE_ID_RST = 4'h0;

    // Command patterns in the lower twelve bits; set device id matches the upper twelve
    localparam logic [11:0] CMD_DRIVER_ENABLE = 12'h009;
    localparam logic [11:0] CMD_DRIVER_DISABLE = 12'h00a;
    localparam logic [11:0] CMD_ENTER_CONFIG = 12'h222;
    localparam logic [11:0] CMD_IDLE = 12'h542;
    localparam logic [11:0] CMD_SOFT_REINIT = 12'h708;
    localparam logic [6:0] CMD_READ_TOP = 7'h08;
    localparam logic [6:0] CMD_SET_POINTER_TOP = 7'h60;
    localparam logic [3:0] CMD_WRITE_UPPER_TOP = 4'ha;
    localparam logic [3:0] CMD_WRITE_LOWER_TOP = 4'hb;
    localparam logic [11:0] CMD_SET_DEVICE_ID_TOP = 12'hfda;

    // Register offsets
    localparam logic [4:0] REG_CFG1 = 5'h00;
    localparam logic [4:0] REG_CFG2 = 5'h01;
    localparam logic [4:0] REG_CFG8 = 5'h07;
    localparam logic [4:0] REG_ADC_FIRST = 5'h0b;
    localparam logic [4:0] REG_ADC_LAST = 5'h12;
    localparam logic [4:0] REG_DEVICE_ID = 5'h15;
    localparam logic [4:0] REG_STATUS1 = 5'h16;
    localparam logic [4:0] REG_SECOND_STATUS_WORD = 5'h17;
    localparam logic [4:0] REG_STATUS_LAST = 5'h1a;
    localparam logic [4:0] REG_CONTROL2 = 5'h1c;
    localparam logic [4:0] REG_LAST = 5'h1e;

    // Reset values and field positions
    localparam logic [15:0] CFG1_RST = 16'h0c00;
    localparam logic [15:0] CFG2_RST = 16'h0200;
    localparam logic [15:0] REG_ZERO_RST = 16'h0000;
    localparam logic [15:0] CFG8_ACTIVE_MASK = 16'h0047;
    localparam logic [15:0] CONTROL2_ACTIVE_MASK = 16'h8000;
    localparam logic [15:0] UPPER_LANE = 16'hff00;
    localparam logic [15:0] LOWER_LANE = 16'h00ff;
    localparam int STATE_FIELD_LSB = 0;
    localparam int ENABLE_FLAG_BIT = 0;

    // Pin synchroniser: cs_n idles high
    localparam int PIN_COUNT = 7;
    localparam logic [6:0] PIN_SYNC_RST = 7'h01;

endpackage

// ### rtl/gds_regfile.sv
// Register file of 32 sixteen-bit words with masked writes and registered read
`timescale 1ns/10ps
`default_nettype none
module gds_regfile (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] wmask,
    input wire logic [4:0] raddr,
    output logic [15:0] rdata_q
);
    logic [15:0] mem_q [0:31];

    function automatic logic [15:0] dflt(input int idx);
        if (idx == int'(gds_pkg::REG_CFG1)) begin
            return gds_pkg::CFG1_RST;
        end
        if (idx == int'(gds_pkg::REG_CFG2)) begin
            return gds_pkg::CFG2_RST;
        end
        return gds_pkg::REG_ZERO_RST;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= dflt(i);
            end
            rdata_q <= gds_pkg::REG_ZERO_RST;
        end else begin
            for (int i = 0; i < 32; i++) begin
                if (clear) begin
                    mem_q[i] <= dflt(i);
                end else if (we && waddr == 5'(i)) begin
                    mem_q[i] <= (mem_q[i] & ~wmask) | (wdata & wmask);
                end
            end
            rdata_q <= mem_q[raddr];
        end
    end
endmodule
`default_nettype wire

// ### rtl/gds_spi_link.sv
// Serial-clock side shifter: samples on falling edge, launches on rising edge
`timescale 1ns/10ps
`default_nettype none
module gds_spi_link (
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic [15:0] tx_word,
    input wire logic out_en_req,
    output logic sdo_q,
    output logic sdo_oe_q,
    output logic [15:0] rx_q,
    output logic frame_full_q
);
    logic [4:0] cnt_q;
    logic [4:0] bits_q;
    logic [4:0] bits_d;
    wire link_rst = rst | cs_n;
    wire first_bit = (cnt_q == 5'h00);
    wire [4:0] full_count = 5'(gds_pkg::FRAME_BITS);

    assign bits_d = first_bit ? 5'h01 : ((bits_q == full_count) ? bits_q : bits_q + 5'h01);
    wire full_step = (bits_d == full_count) && (bits_q != full_count);

    // Counter held in reset while deselected
    always_ff @(negedge sclk or posedge link_rst) begin
        if (link_rst) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != full_count) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Shift word survives deselect so the core can still copy it
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            rx_q <= 16'h0000;
            bits_q <= 5'h00;
            frame_full_q <= 1'b0;
        end else begin
            rx_q <= first_bit ? {tx_word[14:0], serial_in} : {rx_q[14:0], serial_in};
            bits_q <= bits_d;
            // Toggles once per full frame, so a clockless select pulse replays nothing
            frame_full_q <= frame_full_q ^ full_step;
        end
    end

    // Output released whenever the frame ends
    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else begin
            sdo_q <= first_bit ? tx_word[15] : rx_q[15];
            sdo_oe_q <= out_en_req;
        end
    end
endmodule
`default_nettype wire

// ### rtl/gds_core.sv
// Gate driver serial command decoder and operating state machine
`timescale 1ns/10ps
`default_nettype none
module gds_core (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SPI_SCLK,
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_IN,
    input wire logic SECONDARY_SUPPLY_OK,
    input wire logic SELF_TEST_DONE,
    input wire logic PRIMARY_OVERTEMP,
    input wire logic GATE_IN_POS,
    input wire logic GATE_IN_NEG,
    input wire logic UNMASKED_FAULT,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE,
    output logic FAULT_OUTPUTS_N,
    output logic GATE_SOURCE_OUTPUT,
    output logic GATE_SOURCE_OE,
    output logic GATE_SINK_OUTPUT,
    output logic GATE_SINK_OE,
    output logic [1:0] OPERATING_STATE,
    output logic ENABLE_RECEIVED,
    output logic SELF_TEST_RUN,
    output logic CONVERTER_RUN,
    output logic CHECKSUM_CAPTURE
);
    // Pin synchronisers; first stage feeds only the second
    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pin_meta_q <= gds_pkg::PIN_SYNC_RST;
            pin_sync_q <= gds_pkg::PIN_SYNC_RST;
        end else begin
            pin_meta_q <= {UNMASKED_FAULT, GATE_IN_NEG, GATE_IN_POS, PRIMARY_OVERTEMP,
                           SELF_TEST_DONE, SECONDARY_SUPPLY_OK, CHIP_SELECT_N};
            pin_sync_q <= pin_meta_q;
        end
    end
    wire cs_n_s = pin_sync_q[0];
    wire supply_s = pin_sync_q[1];
    wire selftest_s = pin_sync_q[2];
    wire prim_ot_s = pin_sync_q[3];
    wire in_pos_s = pin_sync_q[4];
    wire in_neg_s = pin_sync_q[5];
    wire fault_s = pin_sync_q[6];

    // Link side
    logic [15:0] tx_word_q;
    logic sdo_en_q;
    logic [15:0] link_rx;
    logic link_full;
    gds_spi_link u_link (
        .sclk(SPI_SCLK),
        .rst(RST),
        .cs_n(CHIP_SELECT_N),
        .serial_in(SERIAL_IN),
        .tx_word(tx_word_q),
        .out_en_req(sdo_en_q),
        .sdo_q(SERIAL_OUT),
        .sdo_oe_q(SERIAL_OUT_OE),
        .rx_q(link_rx),
        .frame_full_q(link_full)
    );

    // Frame capture: link word quiet once select has risen; a moved toggle means a new frame
    logic cs_prev_q;
    logic [15:0] rx_q;
    logic exec_q;
    logic full_seen_q;
    wire frame_end = cs_n_s & ~cs_prev_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cs_prev_q <= 1'b1;
            rx_q <= 16'h0000;
            exec_q <= 1'b0;
            full_seen_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_n_s;
            exec_q <= frame_end & (link_full ^ full_seen_q);
            if (frame_end) begin
                rx_q <= link_rx;
                full_seen_q <= link_full;
            end
        end
    end

    gds_pkg::gds_state_t state_q;
    gds_pkg::gds_state_t state_d;
    logic [3:0] device_id_q;
    logic [4:0] ptr_q;
    logic driver_disable_cmd_q;
    logic flag_q;

    // Address and command decode
    wire [3:0] frame_id = rx_q[gds_pkg::ADDR_MSB:gds_pkg::ADDR_LSB];
    wire id_own = (frame_id == device_id_q);
    wire id_bcast = (frame_id == gds_pkg::ADDR_BCAST);
    wire id_ok = id_own | id_bcast | (frame_id == gds_pkg::ADDR_ZERO);
    wire live = exec_q & id_ok & (state_q != gds_pkg::ST_RESET);
    wire [11:0] body = rx_q[11:0];
    wire is_en = (body == gds_pkg::CMD_DRIVER_ENABLE);
    wire is_dis = (body == gds_pkg::CMD_DRIVER_DISABLE);
    wire is_cfgin = (body == gds_pkg::CMD_ENTER_CONFIG);
    wire is_idle = (body == gds_pkg::CMD_IDLE);
    wire is_swr = (body == gds_pkg::CMD_SOFT_REINIT);
    wire is_rd = (body[11:5] == gds_pkg::CMD_READ_TOP);
    wire is_ptr = (body[11:5] == gds_pkg::CMD_SET_POINTER_TOP);
    wire is_wrh = (body[11:8] == gds_pkg::CMD_WRITE_UPPER_TOP);
    wire is_wrl = (body[11:8] == gds_pkg::CMD_WRITE_LOWER_TOP);
    wire is_setid = (rx_q[15:4] == gds_pkg::CMD_SET_DEVICE_ID_TOP);
    // Idle needs no action; unknown patterns fall through every command branch but still set serial output ownership
    wire known = is_en | is_dis | is_cfgin | is_idle | is_swr | is_rd | is_ptr
                 | is_wrh | is_wrl | is_setid;
    wire act = live & known;

    wire in_active = (state_q == gds_pkg::ST_ACTIVE);
    wire in_regcfg = (state_q == gds_pkg::ST_REG_CFG);
    wire regs_clear = (state_q == gds_pkg::ST_RESET) | (act & is_swr);
    wire entering_active = in_regcfg & (state_d == gds_pkg::ST_ACTIVE);

    // Write permission per state
    wire ro_reg = ((ptr_q >= gds_pkg::REG_ADC_FIRST) && (ptr_q <= gds_pkg::REG_ADC_LAST))
                  || ((ptr_q >= gds_pkg::REG_STATUS1) && (ptr_q <= gds_pkg::REG_STATUS_LAST))
                  || (ptr_q == gds_pkg::REG_DEVICE_ID) || (ptr_q > gds_pkg::REG_LAST);
    wire [15:0] active_mask = (ptr_q == gds_pkg::REG_CFG8) ? gds_pkg::CFG8_ACTIVE_MASK :
                              (ptr_q == gds_pkg::REG_CONTROL2) ? gds_pkg::CONTROL2_ACTIVE_MASK :
                              16'h0000;
    wire [15:0] perm_mask = in_regcfg ? (ro_reg ? 16'h0000 : 16'hffff) :
                            in_active ? active_mask : 16'h0000;
    wire [15:0] lane = is_wrh ? gds_pkg::UPPER_LANE : gds_pkg::LOWER_LANE;
    wire wr_we = act & (is_wrh | is_wrl) & ~is_setid;
    wire [15:0] wr_mask = perm_mask & lane;
    wire [15:0] wr_data = {rx_q[7:0], rx_q[7:0]};

    // Read pipeline: read address, memory, then transmit word
    logic [4:0] rd_addr_q;
    logic rd_stage1_q;
    logic rd_stage2_q;
    logic [15:0] mem_rdata;
    gds_regfile u_regs (
        .clk(CLK),
        .rst(RST),
        .clear(regs_clear),
        .we(wr_we),
        .waddr(ptr_q),
        .wdata(wr_data),
        .wmask(wr_mask),
        .raddr(rd_addr_q),
        .rdata_q(mem_rdata)
    );

    wire state_visible = in_regcfg | in_active;
    wire [1:0] state_code = 2'(state_q);
    wire [15:0] status1_word = state_visible ?
                               16'({state_code} << gds_pkg::STATE_FIELD_LSB) : 16'h0000;
    wire [15:0] second_status_word_word = 16'({flag_q} << gds_pkg::ENABLE_FLAG_BIT);
    wire [15:0] read_word = (rd_addr_q == gds_pkg::REG_STATUS1) ? status1_word :
                            (rd_addr_q == gds_pkg::REG_SECOND_STATUS_WORD) ? second_status_word_word :
                            (rd_addr_q == gds_pkg::REG_DEVICE_ID) ? {12'h000, device_id_q} :
                            mem_rdata;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_addr_q <= 5'h00;
            rd_stage1_q <= 1'b0;
            rd_stage2_q <= 1'b0;
            tx_word_q <= 16'h0000;
        end else begin
            rd_stage1_q <= act & is_rd;
            rd_stage2_q <= rd_stage1_q;
            if (act & is_rd) begin
                rd_addr_q <= rx_q[4:0];
            end
            // One frame of read data, then back to zeros
            if (rd_stage2_q) begin
                tx_word_q <= read_word;
            end else if (frame_end) begin
                tx_word_q <= 16'h0000;
            end
        end
    end

    // Serial output ownership
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sdo_en_q <= 1'b0;
        end else if (exec_q && state_q != gds_pkg::ST_RESET) begin
            if (id_own && !id_bcast) begin
                sdo_en_q <= 1'b1;
            end else if (id_bcast || !id_ok) begin
                sdo_en_q <= 1'b0;
            end
        end
    end

    // Pointer and device id
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ptr_q <= 5'h00;
            device_id_q <= gds_pkg::DEVICE_ID_RST;
        end else begin
            if (regs_clear) begin
                ptr_q <= 5'h00;
            end else if (act && is_ptr) begin
                ptr_q <= rx_q[4:0];
            end
            // Soft reinit keeps the id; only the reset state clears it
            if (state_q == gds_pkg::ST_RESET) begin
                device_id_q <= gds_pkg::DEVICE_ID_RST;
            end else if (act && is_setid && in_pos_s
                         && state_q == gds_pkg::ST_ADDR_CFG) begin
                device_id_q <= rx_q[3:0];
            end
        end
    end

    // Operating state
    always_comb begin
        state_d = state_q;
        case (state_q)
            gds_pkg::ST_RESET: begin
                if (supply_s && selftest_s) begin
                    state_d = gds_pkg::ST_ADDR_CFG;
                end
            end
            gds_pkg::ST_ADDR_CFG: begin
                if (act && is_cfgin) begin
                    state_d = gds_pkg::ST_REG_CFG;
                end
            end
            gds_pkg::ST_REG_CFG: begin
                if (act && is_swr) begin
                    state_d = gds_pkg::ST_ADDR_CFG;
                end else if (act && is_en) begin
                    state_d = gds_pkg::ST_ACTIVE;
                end
            end
            gds_pkg::ST_ACTIVE: begin
                if (act && is_swr) begin
                    state_d = gds_pkg::ST_ADDR_CFG;
                end else if (act && is_cfgin && driver_disable_cmd_q) begin
                    state_d = gds_pkg::ST_REG_CFG;
                end
            end
            default: begin
                state_d = gds_pkg::ST_RESET;
            end
        endcase
        // Secondary over-temperature has no path here
        if (prim_ot_s) begin
            state_d = gds_pkg::ST_RESET;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= gds_pkg::ST_RESET;
            driver_disable_cmd_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!in_active || entering_active) begin
                driver_disable_cmd_q <= 1'b0;
            end else if (act && is_dis) begin
                driver_disable_cmd_q <= 1'b1;
            end
            if (entering_active) begin
                flag_q <= 1'b1;
            end else if (regs_clear) begin
                flag_q <= 1'b0;
            end
        end
    end

    // Pin-facing outputs
    wire drive_on = in_active & ~driver_disable_cmd_q & ~fault_s;
    wire gate_high = drive_on & in_pos_s & ~in_neg_s;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FAULT_OUTPUTS_N <= 1'b0;
            GATE_SOURCE_OUTPUT <= 1'b0;
            GATE_SOURCE_OE <= 1'b0;
            GATE_SINK_OUTPUT <= 1'b0;
            GATE_SINK_OE <= 1'b0;
            OPERATING_STATE <= 2'h0;
            ENABLE_RECEIVED <= 1'b0;
            SELF_TEST_RUN <= 1'b1;
            CONVERTER_RUN <= 1'b0;
            CHECKSUM_CAPTURE <= 1'b0;
        end else begin
            FAULT_OUTPUTS_N <= (state_q == gds_pkg::ST_ADDR_CFG) | (state_visible & ~fault_s);
            GATE_SOURCE_OUTPUT <= gate_high;
            GATE_SOURCE_OE <= gate_high;
            GATE_SINK_OUTPUT <= 1'b0;
            GATE_SINK_OE <= (state_q != gds_pkg::ST_RESET) & ~gate_high;
            OPERATING_STATE <= state_code;
            ENABLE_RECEIVED <= flag_q;
            SELF_TEST_RUN <= (state_q == gds_pkg::ST_RESET);
            CONVERTER_RUN <= in_active;
            CHECKSUM_CAPTURE <= entering_active;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_reset_floats: assert property (state_q == gds_pkg::ST_RESET |=> !GATE_SOURCE_OE && !GATE_SINK_OE)
        else $error("gate outputs driven in reset state");
    a_fault_held: assert property (state_q == gds_pkg::ST_RESET |=> !FAULT_OUTPUTS_N)
        else $error("fault outputs released during reset");
    a_fault_release: assert property (state_q == gds_pkg::ST_ADDR_CFG |=> FAULT_OUTPUTS_N)
        else $error("fault outputs not released in address state");
    a_overtemp_reset: assert property (prim_ot_s |=> state_q == gds_pkg::ST_RESET)
        else $error("primary overtemperature did not force reset");
    a_sink_low: assert property ((state_q == gds_pkg::ST_ADDR_CFG || in_regcfg) |=> GATE_SINK_OE && !GATE_SINK_OUTPUT && !GATE_SOURCE_OE)
        else $error("sink not held low in configuration");
    a_enable_flag: assert property ($rose(in_active) |-> flag_q && CHECKSUM_CAPTURE ##1 ENABLE_RECEIVED)
        else $error("enable flag or checksum capture missing on entry");
    a_active_locked: assert property (in_active && wr_we && ptr_q != gds_pkg::REG_CFG8 && ptr_q != gds_pkg::REG_CONTROL2 |-> wr_mask == 16'h0000)
        else $error("write permitted in active state");
    a_pointer_hold: assert property (exec_q && !(live && is_ptr) && !regs_clear |=> $stable(ptr_q))
        else $error("pointer changed without pointer command");
    a_read_load: assert property (act && is_rd |-> ##3 tx_word_q == $past(read_word))
        else $error("read data not loaded for next frame");
endmodule
`default_nettype wire

// ### dv/gds_host_model.sv
// Host serial master model that frames and clocks commands into the device
`timescale 1ns/10ps
`default_nettype none
module gds_host_model (
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic sdo_oe
);
    logic oe_seen;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        oe_seen = 1'b0;
    end
    // Clock stands still outside frames; launch on rising, sample on falling
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        cs_n = 1'b0;
        #37;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b1;
            serial_in = w[i];
            #15;
            sclk = 1'b0;
            // Undriven line has no pull, so it shows the inverse of the last value
            r[i] = sdo_oe ? serial_out : ~serial_out;
            oe_seen = sdo_oe;
            #15;
        end
        #20;
        cs_n = 1'b1;
        // Released line must not look like held data
        serial_in = ~serial_in;
        // Gap covers execute plus read data load
        #643;
    endtask
endmodule
`default_nettype wire

// ### dv/gds_core_tb.sv
// Self-checking bench for the gate driver serial front end
`timescale 1ns/10ps
`default_nettype none
module gds_core_tb;
    logic clk, rst, sclk, cs_n, serial_in, sup_ok, st_done, otp, in_pos, in_neg, flt;
    logic serial_out, sdo_oe, flt_n, src, src_oe, snk, snk_oe, en_rcvd, st_run, conv, cks;
    logic [1:0] state;
    logic [15:0] rd;
    int bad_count, check_count;
    int cks_count;

    // Checksum capture is a one-cycle pulse; count it where it stands
    always @(negedge clk) begin
        if (cks === 1'b1) begin
            cks_count++;
        end
    end

    gds_core gds_core_inst (.CLK(clk), .RST(rst), .SPI_SCLK(sclk), .CHIP_SELECT_N(cs_n),
        .SERIAL_IN(serial_in), .SECONDARY_SUPPLY_OK(sup_ok), .SELF_TEST_DONE(st_done),
        .PRIMARY_OVERTEMP(otp), .GATE_IN_POS(in_pos), .GATE_IN_NEG(in_neg),
        .UNMASKED_FAULT(flt), .SERIAL_OUT(serial_out), .SERIAL_OUT_OE(sdo_oe),
        .FAULT_OUTPUTS_N(flt_n), .GATE_SOURCE_OUTPUT(src), .GATE_SOURCE_OE(src_oe),
        .GATE_SINK_OUTPUT(snk), .GATE_SINK_OE(snk_oe), .OPERATING_STATE(state),
        .ENABLE_RECEIVED(en_rcvd), .SELF_TEST_RUN(st_run), .CONVERTER_RUN(conv),
        .CHECKSUM_CAPTURE(cks));
    gds_host_model gds_host_model_inst (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
        .sdo_oe(sdo_oe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic send(input logic [15:0] w);
        gds_host_model_inst.frame(w, rd);
        hold(1);
    endtask
    // Read data comes back during the following idle frame
    task automatic rdreg(input logic [15:0] w);
        send(w);
        send(16'h5542);
    endtask
    task automatic st(input logic [1:0] exp);
        chk("state", {14'h0, exp}, {14'h0, state});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        {sup_ok, st_done, otp, in_pos, in_neg, flt} = 6'h00;
        hold(8);
        rst = 1'b0;
        hold(4);
        chk("reset pins", 16'h0008, {12'h0, st_run, src_oe, snk_oe, flt_n});
        send(16'h0222);
        st(2'h0);
        {sup_ok, st_done} = 2'h3;
        hold(10);
        st(2'h1);
        chk("addr pins", 16'h0003, {13'h0, st_run, snk_oe, flt_n});
        $display("test reset done");
        send(16'hfdaa);
        send(16'ha222);
        st(2'h1);
        in_pos = 1'b1;
        send(16'hfda5);
        send(16'h5222);
        st(2'h2);
        send(16'h3009);
        send(16'h5fff);
        st(2'h2);
        chk("cfg pins", 16'h0004, {13'h0, snk_oe, snk, src_oe | conv});
        send(16'h5c00);
        send(16'h5a12);
        rdreg(16'h5100);
        chk("upper", 16'h1200, rd);
        send(16'h5b34);
        rdreg(16'h5100);
        chk("lower", 16'h1234, rd);
        rdreg(16'h5116);
        chk("state field", 16'h0002, rd & 16'h0003);
        flt = 1'b1;
        hold(6);
        chk("fault pin", 16'h0000, {15'h0, flt_n});
        flt = 1'b0;
        send(16'hf542);
        send(16'h5542);
        chk("oe bcast", 16'h0000, {15'h0, gds_host_model_inst.oe_seen});
        send(16'h5542);
        chk("oe own", 16'h0001, {15'h0, gds_host_model_inst.oe_seen});
        chk("oe idle", 16'h0000, {15'h0, sdo_oe});
        $display("test config done");
        send(16'h5009);
        st(2'h3);
        chk("active", 16'h000f, {12'h0, en_rcvd, conv, src, src_oe});
        chk("checksum", 16'h0001, 16'(cks_count));
        in_neg = 1'b1;
        hold(6);
        chk("gate follow", 16'h0000, {15'h0, src});
        in_neg = 1'b0;
        flt = 1'b1;
        hold(6);
        chk("gate fault", 16'h0000, {15'h0, src});
        flt = 1'b0;
        send(16'h5aff);
        rdreg(16'h5100);
        chk("ro cfg1", 16'h1234, rd);
        send(16'h5c07);
        send(16'h5bff);
        rdreg(16'h5107);
        chk("cfg8", 16'h0047, rd);
        rdreg(16'h5117);
        chk("enable flag", 16'h0001, rd & 16'h0001);
        send(16'h500a);
        st(2'h3);
        chk("disabled", 16'h0000, {15'h0, src});
        send(16'h5222);
        st(2'h2);
        rdreg(16'h5100);
        chk("kept", 16'h1234, rd);
        send(16'h5009);
        st(2'h3);
        send(16'h5708);
        st(2'h1);
        chk("reinit off", 16'h0000, {15'h0, src});
        send(16'h5222);
        st(2'h2);
        rdreg(16'h5100);
        chk("defaults", 16'h0c00, rd);
        $display("test active done");
        otp = 1'b1;
        hold(8);
        st(2'h0);
        otp = 1'b0;
        hold(10);
        st(2'h1);
        $display("test overtemp done");
        report_and_stop();
    end
endmodule
`default_nettype wire
